// [logic/lp2_consts.svh]
// timing and encoding constants for the lpddr2 precharge and refresh pair
`ifndef LP2_CONSTS_SVH
`define LP2_CONSTS_SVH

`define LP2_NBANK      8
`define LP2_TCK_PS     25000
// latencies in clocks, burst length in words
`define LP2_WL         2
`define LP2_RL         3
`define LP2_BL         8
`define LP2_BLH        (`LP2_BL / 2)
// analog times in ps
`define LP2_TWR_PS     15000
`define LP2_TRTP_PS    7500
`define LP2_TRPPB_PS   18000
`define LP2_TRAS_PS    42000
`define LP2_TRC_PS     60000
`define LP2_TRFCAB_PS  130000
`define LP2_TWTR_PS    7500
`define LP2_TDQSCK_PS  5500
// rounded up to whole clocks
`define LP2_RU(t)      (((t) + `LP2_TCK_PS - 1) / `LP2_TCK_PS)
`define LP2_WR_CK      `LP2_RU(`LP2_TWR_PS)
`define LP2_RTP_CK     `LP2_RU(`LP2_TRTP_PS)
`define LP2_RP_CK      `LP2_RU(`LP2_TRPPB_PS)
`define LP2_RAS_CK     `LP2_RU(`LP2_TRAS_PS)
`define LP2_RC_CK      `LP2_RU(`LP2_TRC_PS)
`define LP2_RFC_CK     `LP2_RU(`LP2_TRFCAB_PS)
`define LP2_WTR_CK     `LP2_RU(`LP2_TWTR_PS)
`define LP2_DQSCK_CK   `LP2_RU(`LP2_TDQSCK_PS)
// command spacings in clocks
`define LP2_RD2PRE     (`LP2_BLH + ((`LP2_RTP_CK > 2) ? `LP2_RTP_CK : 2) - 2)
`define LP2_WR2PRE     (`LP2_WL + `LP2_BLH + `LP2_WR_CK + 1)
`define LP2_BST2PRE_RD 1
`define LP2_BST2PRE_WR (`LP2_WL + `LP2_WR_CK + 1)
`define LP2_RDAP2ACT   (`LP2_RD2PRE + `LP2_RP_CK)
`define LP2_WRAP2ACT   (`LP2_WR2PRE + `LP2_RP_CK)
`define LP2_RD2WR      (`LP2_RL + `LP2_BLH + `LP2_DQSCK_CK - `LP2_WL + 1)
`define LP2_RD2RD      `LP2_BLH
`define LP2_WR2RD      (`LP2_WL + `LP2_BLH + `LP2_WTR_CK + 1)
`define LP2_WR2WR      `LP2_BLH
`define LP2_PRE2PRE    1
// ca bit positions, rising and falling halves
`define LP2_AB_POS     4
`define LP2_BA_LSB     7
`define LP2_AP_POS     0

`endif

// [logic/lp2_pkg.sv]
// types shared by both ends of the lpddr2 command link
`default_nettype none
package lp2_pkg;
   typedef logic [7:0] lp2_cnt_t;

   typedef enum logic [2:0] {
      CMD_NOP  = 3'h0,
      CMD_ACT  = 3'h1,
      CMD_RD   = 3'h2,
      CMD_WR   = 3'h3,
      CMD_PRE  = 3'h4,
      CMD_PREA = 3'h5,
      CMD_REFA = 3'h6
   } lp2_cmd_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DATA = 2'b11
   } lp2_st_e;

   typedef struct packed {
      logic [7:0]       bankOpen;
      logic [7:0]       prech;
      lp2_cnt_t [7:0]   rpCnt;
      lp2_cnt_t [7:0]   apCnt;
      logic [7:0]       apStart;
      lp2_cnt_t         refCnt;
      logic             refBusy;
      logic [2:0]       bankCnt;
      logic [2:0]       wrBank;
      lp2_cnt_t         wrLeft;
      logic             half;
      logic [63:0]      grp;
      logic             arrayWr;
      logic [2:0]       arrayBank;
      logic [127:0]     arrayData;
   } lp2_dev_s;

   typedef struct packed {
      lp2_st_e          st;
      logic             csB;
      logic [9:0]       caR;
      logic [9:0]       caF;
      logic [63:0]      wdq;
      logic             wdqValid;
      logic             reqAck;
      logic             usrWrTake;
      logic [7:0]       bankOpen;
      lp2_cnt_t [7:0]   rpCnt;
      lp2_cnt_t [7:0]   actCnt;
      lp2_cnt_t [7:0]   preCnt;
      lp2_cnt_t         rdCnt;
      lp2_cnt_t         wrCnt;
      lp2_cnt_t         refCnt;
      lp2_cnt_t         wdDelay;
      lp2_cnt_t         wdLeft;
   } lp2_ctl_s;

   function automatic lp2_cnt_t lp2_max(lp2_cnt_t a, lp2_cnt_t b);
      return (a > b) ? a : b;
   endfunction : lp2_max

   function automatic lp2_cnt_t lp2_dec(lp2_cnt_t a);
      return (a != 8'h00) ? a - 8'h01 : 8'h00;
   endfunction : lp2_dec
endpackage : lp2_pkg
`default_nettype wire

// [logic/lp2_link_if.sv]
// command, address and write data link between controller and device
`timescale 1ns/100ps
`default_nettype none
interface lp2_link_if (
   input wire logic mclk
);
   logic        csB;
   logic [9:0]  caR;
   logic [9:0]  caF;
   logic [63:0] wdq;
   logic        wdqValid;

   modport dev (input mclk, input csB, input caR, input caF, input wdq, input wdqValid);
   modport ctl (input mclk, output csB, output caR, output caF, output wdq, output wdqValid);
endinterface : lp2_link_if
`default_nettype wire

// [logic/lp2_device.sv]
// sdram die end: decodes commands, runs auto-precharge, refresh, write commit
`timescale 1ns/100ps
`default_nettype none
`include "lp2_consts.svh"
module lp2_device (
   lp2_link_if.dev            link,
   input  wire logic          rst_b,
   output logic [7:0]         devBankOpen,
   output logic [7:0]         devBankPrech,
   output logic [7:0]         devApStart,
   output logic               devRefBusy,
   output logic [2:0]         devBankCnt,
   output logic               arrayWr,
   output logic [2:0]         arrayBank,
   output logic [127:0]       arrayData
);
   import lp2_pkg::*;

   lp2_dev_s s_q;
   lp2_dev_s s_d;
   logic [2:0] ba;

   assign ba = link.caR[`LP2_BA_LSB +: 3];

   always_comb begin
      s_d = s_q;
      s_d.arrayWr = 1'b0;
      s_d.apStart = 8'h00;
      s_d.refCnt = lp2_dec(s_q.refCnt);
      for (int b = 0; b < `LP2_NBANK; b++) begin
         s_d.rpCnt[b] = lp2_dec(s_q.rpCnt[b]);
         if (s_q.apCnt[b] != 8'h00) begin
            s_d.apCnt[b] = s_q.apCnt[b] - 8'h01;
            if (s_q.apCnt[b] == 8'h01) begin
               // auto-precharge starts on this edge
               s_d.bankOpen[b] = 1'b0;
               s_d.rpCnt[b] = lp2_cnt_t'(`LP2_RP_CK);
               s_d.apStart[b] = 1'b1;
            end
         end
      end
      // write data: two words a clock, committed per four-word group
      if (link.wdqValid && s_q.wrLeft != 8'h00) begin
         s_d.wrLeft = s_q.wrLeft - 8'h01;
         if (!s_q.half) begin
            s_d.grp = link.wdq;
            s_d.half = 1'b1;
         end else begin
            s_d.arrayData = {link.wdq, s_q.grp};
            s_d.arrayBank = s_q.wrBank;
            s_d.arrayWr = 1'b1;
            s_d.half = 1'b0;
         end
      end
      if (!link.csB) begin
         if (link.caR[1:0] == 2'b10) begin
            s_d.bankOpen[ba] = 1'b1;
         end else if (link.caR[2:0] == 3'b001) begin
            s_d.wrBank = ba;
            s_d.wrLeft = lp2_cnt_t'(`LP2_BLH);
            s_d.half = 1'b0;
            if (link.caF[`LP2_AP_POS]) begin
               s_d.apCnt[ba] = lp2_cnt_t'(`LP2_WR2PRE);
            end
         end else if (link.caR[2:0] == 3'b101) begin
            if (link.caF[`LP2_AP_POS]) begin
               s_d.apCnt[ba] = lp2_cnt_t'(`LP2_RD2PRE);
            end
         end else if (link.caR[3:0] == 4'b1011) begin
            for (int b = 0; b < `LP2_NBANK; b++) begin
               if (link.caR[`LP2_AB_POS] || ba == 3'(b)) begin
                  s_d.bankOpen[b] = 1'b0;
                  s_d.rpCnt[b] = lp2_cnt_t'(`LP2_RP_CK);
               end
            end
         end else if (link.caR[3:0] == 4'b1100) begin
            s_d.bankOpen = 8'h00;
            s_d.apCnt = '0;
            s_d.refCnt = lp2_cnt_t'(`LP2_RFC_CK);
            s_d.bankCnt = 3'h0;
         end
      end
      for (int b = 0; b < `LP2_NBANK; b++) begin
         s_d.prech[b] = (s_d.rpCnt[b] != 8'h00);
      end
      s_d.refBusy = (s_d.refCnt != 8'h00);
   end

   always_ff @(posedge link.mclk) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign devBankOpen  = s_q.bankOpen;
   assign devBankPrech = s_q.prech;
   assign devApStart   = s_q.apStart;
   assign devRefBusy   = s_q.refBusy;
   assign devBankCnt   = s_q.bankCnt;
   assign arrayWr      = s_q.arrayWr;
   assign arrayBank    = s_q.arrayBank;
   assign arrayData    = s_q.arrayData;
endmodule : lp2_device
`default_nettype wire

// [logic/lp2_controller.sv]
// memory controller end: spaces and issues precharge, refresh and burst commands
// Operation
// - write to precharge waits WL+BL/2+1+tWR
// - no precharge before write recovery elapses
// - device commits write data per four words
// - ap bit chooses auto-precharge or open bank
// - read-ap precharge starts at later bound
// - write-ap precharge starts after write recovery
// - activate after ap needs tRP and tRC
// - read to precharge waits BL/2+max(2,tRTP)-2
// - read burst terminate to precharge one clock
// - read-ap to activate adds tRPpb
// - read-ap spacing to other-bank reads, writes
// - write terminate to precharge WL+tWR+1
// - write-ap to activate adds tRPpb
// - write-ap spacing to other-bank reads, writes
// - ap bursts never interrupted or truncated
// - precharges one clock apart, latest counts
// - no command inside any minimum window
// - refresh decode, CA3 high means all banks
// - refresh needs idle banks, tRP, tRFCab
// - all-bank refresh zeroes device bank counter
// - tRFCab before activate or refresh
// - precharge encoding, AB or bank address
`timescale 1ns/100ps
`default_nettype none
`include "lp2_consts.svh"
module lp2_controller (
   input  wire logic          mclk,
   input  wire logic          rst_b,
   lp2_link_if.ctl            link,
   input  wire logic          reqValid,
   input  wire lp2_pkg::lp2_cmd_e reqCmd,
   input  wire logic [2:0]    reqBank,
   input  wire logic          reqAp,
   input  wire logic [63:0]   usrWrData,
   output logic               reqAck,
   output logic               usrWrTake,
   output logic [7:0]         ctlBankOpen,
   output logic               ctlRefBusy
);
   import lp2_pkg::*;

   lp2_ctl_s s_q;
   lp2_ctl_s s_d;
   logic     legal;
   logic     issue;
   logic     dataBusy;
   logic     allPreOk;
   logic     allRpOk;

   always_comb begin
      allPreOk = 1'b1;
      allRpOk = 1'b1;
      for (int b = 0; b < `LP2_NBANK; b++) begin
         if (s_q.preCnt[b] != 8'h00) begin
            allPreOk = 1'b0;
         end
         if (s_q.rpCnt[b] != 8'h00) begin
            allRpOk = 1'b0;
         end
      end
      // write data path busy: no new write, no truncation of a burst
      dataBusy = (s_q.wdDelay != 8'h00) || (s_q.wdLeft != 8'h00);
      legal = 1'b0;
      unique case (reqCmd)
         CMD_ACT: begin
            legal = !s_q.bankOpen[reqBank] && s_q.actCnt[reqBank] == 8'h00
                    && s_q.rpCnt[reqBank] == 8'h00 && s_q.refCnt == 8'h00;
         end
         CMD_RD: begin
            legal = s_q.bankOpen[reqBank] && s_q.rdCnt == 8'h00;
         end
         CMD_WR: begin
            legal = s_q.bankOpen[reqBank] && s_q.wrCnt == 8'h00 && !dataBusy;
         end
         CMD_PRE: begin
            legal = s_q.preCnt[reqBank] == 8'h00;
         end
         CMD_PREA: begin
            legal = allPreOk;
         end
         CMD_REFA: begin
            legal = s_q.bankOpen == 8'h00 && allRpOk && s_q.refCnt == 8'h00;
         end
         default: begin
            legal = 1'b0;
         end
      endcase
      issue = reqValid && legal && !s_q.reqAck && s_q.st != ST_DATA;
   end

   always_comb begin
      s_d = s_q;
      s_d.csB = 1'b1;
      s_d.caR = 10'h000;
      s_d.caF = 10'h000;
      s_d.reqAck = 1'b0;
      s_d.wdqValid = 1'b0;
      s_d.usrWrTake = 1'b0;
      s_d.rdCnt = lp2_dec(s_q.rdCnt);
      s_d.wrCnt = lp2_dec(s_q.wrCnt);
      s_d.refCnt = lp2_dec(s_q.refCnt);
      s_d.wdDelay = lp2_dec(s_q.wdDelay);
      for (int b = 0; b < `LP2_NBANK; b++) begin
         s_d.rpCnt[b] = lp2_dec(s_q.rpCnt[b]);
         s_d.actCnt[b] = lp2_dec(s_q.actCnt[b]);
         s_d.preCnt[b] = lp2_dec(s_q.preCnt[b]);
      end
      // write data, BL/2 clocks starting WL+1 after the command
      if (s_q.wdDelay == 8'h01) begin
         s_d.wdLeft = lp2_cnt_t'(`LP2_BLH);
      end
      if (s_q.wdLeft != 8'h00) begin
         s_d.wdLeft = s_q.wdLeft - 8'h01;
         s_d.wdqValid = 1'b1;
         s_d.wdq = usrWrData;
         s_d.usrWrTake = 1'b1;
      end
      s_d.st = (s_d.wdDelay != 8'h00 || s_d.wdLeft != 8'h00) ? ST_WAIT : ST_IDLE;
      if (issue) begin
         s_d.reqAck = 1'b1;
         s_d.csB = 1'b0;
         s_d.caR[`LP2_BA_LSB +: 3] = reqBank;
         // burst terminate is never sent, so its precharge spacings never arise
         unique case (reqCmd)
            CMD_ACT: begin
               s_d.caR[1:0] = 2'b10;
               s_d.bankOpen[reqBank] = 1'b1;
               s_d.actCnt[reqBank] = lp2_max(s_d.actCnt[reqBank], lp2_cnt_t'(`LP2_RC_CK));
               s_d.preCnt[reqBank] = lp2_max(s_d.preCnt[reqBank], lp2_cnt_t'(`LP2_RAS_CK));
            end
            CMD_RD: begin
               s_d.caR[2:0] = 3'b101;
               s_d.caF[`LP2_AP_POS] = reqAp;
               s_d.preCnt[reqBank] = lp2_max(s_d.preCnt[reqBank],
                                             lp2_cnt_t'(`LP2_RD2PRE));
               s_d.rdCnt = lp2_max(s_d.rdCnt, lp2_cnt_t'(`LP2_RD2RD));
               s_d.wrCnt = lp2_max(s_d.wrCnt, lp2_cnt_t'(`LP2_RD2WR));
               if (reqAp) begin
                  s_d.bankOpen[reqBank] = 1'b0;
                  s_d.rpCnt[reqBank] = lp2_cnt_t'(`LP2_RDAP2ACT);
                  s_d.actCnt[reqBank] = lp2_max(s_d.actCnt[reqBank],
                                                lp2_cnt_t'(`LP2_RDAP2ACT));
               end
            end
            CMD_WR: begin
               s_d.caR[2:0] = 3'b001;
               s_d.caF[`LP2_AP_POS] = reqAp;
               s_d.wdDelay = lp2_cnt_t'(`LP2_WL);
               s_d.st = ST_DATA;
               s_d.preCnt[reqBank] = lp2_max(s_d.preCnt[reqBank],
                                             lp2_cnt_t'(`LP2_WR2PRE));
               s_d.wrCnt = lp2_max(s_d.wrCnt, lp2_cnt_t'(`LP2_WR2WR));
               s_d.rdCnt = lp2_max(s_d.rdCnt, lp2_cnt_t'(`LP2_WR2RD));
               if (reqAp) begin
                  s_d.bankOpen[reqBank] = 1'b0;
                  s_d.rpCnt[reqBank] = lp2_cnt_t'(`LP2_WRAP2ACT);
                  s_d.actCnt[reqBank] = lp2_max(s_d.actCnt[reqBank],
                                                lp2_cnt_t'(`LP2_WRAP2ACT));
               end
            end
            CMD_PRE, CMD_PREA: begin
               s_d.caR[3:0] = 4'b1011;
               s_d.caR[`LP2_AB_POS] = (reqCmd == CMD_PREA);
               for (int b = 0; b < `LP2_NBANK; b++) begin
                  if (reqCmd == CMD_PREA || reqBank == 3'(b)) begin
                     s_d.bankOpen[b] = 1'b0;
                     s_d.rpCnt[b] = lp2_cnt_t'(`LP2_RP_CK);
                     s_d.actCnt[b] = lp2_max(s_d.actCnt[b], lp2_cnt_t'(`LP2_RP_CK));
                     s_d.preCnt[b] = lp2_max(s_d.preCnt[b],
                                             lp2_cnt_t'(`LP2_PRE2PRE - 1));
                  end
               end
            end
            CMD_REFA: begin
               s_d.caR[3:0] = 4'b1100;
               s_d.refCnt = lp2_cnt_t'(`LP2_RFC_CK);
            end
            default: begin
               s_d.csB = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.csB <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.csB     = s_q.csB;
   assign link.caR     = s_q.caR;
   assign link.caF     = s_q.caF;
   assign link.wdq     = s_q.wdq;
   assign link.wdqValid = s_q.wdqValid;
   assign reqAck       = s_q.reqAck;
   assign usrWrTake    = s_q.usrWrTake;
   assign ctlBankOpen  = s_q.bankOpen;
   assign ctlRefBusy   = (s_q.refCnt != 8'h00);
endmodule : lp2_controller
`default_nettype wire

// [test/lp2_link_chk.sv]
// concurrent checks on the controller to device command link
`timescale 1ns/100ps
`default_nettype none
`include "lp2_consts.svh"
module lp2_link_chk (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        csB,
   input wire logic [9:0]  caR,
   input wire logic [9:0]  caF,
   input wire logic [63:0] wdq,
   input wire logic        wdqValid
);
   localparam int WDLY = `LP2_WL + 1;
   logic [2:0]       wrBank_q;
   logic [2:0]       rdBank_q;
   wire logic [2:0]  bnk   = caR[9:7];
   wire logic        isAct = !csB && caR[1:0] == 2'b10;
   wire logic        isWr  = !csB && caR[2:0] == 3'b001;
   wire logic        isRd  = !csB && caR[2:0] == 3'b101;
   wire logic        isPre = !csB && caR[3:0] == 4'b1011;
   wire logic        isRef = !csB && caR[3:0] == 4'b1100;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   // bank of the latest write and read seen on the link
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wrBank_q <= 3'h0;
         rdBank_q <= 3'h0;
      end else begin
         if (isWr) begin
            wrBank_q <= bnk;
         end
         if (isRd) begin
            rdBank_q <= bnk;
         end
      end
   end

   a_idle_link_quiet: assert property (csB |-> caR == 10'h000 && caF == 10'h000)
      else $error("command bits driven while deselected");
   a_wr_data_lat: assert property (isWr |-> ##WDLY wdqValid [*4])
      else $error("write data not on time or too short");
   a_no_stray_data: assert property ($rose(wdqValid) |-> $past(isWr, 3))
      else $error("write data without a write");
   a_wr_to_pre: assert property (isWr |=> (!(isPre && (caR[4] || bnk == wrBank_q))) [*7])
      else $error("precharge too soon after write");
   a_rd_to_pre: assert property (isRd |=> (!(isPre && (caR[4] || bnk == rdBank_q))) [*3])
      else $error("precharge too soon after read");
   a_rdap_to_act: assert property (isRd && caF[0] |=> (!(isAct && bnk == rdBank_q)) [*4])
      else $error("activate too soon after read with auto precharge");
   a_wrap_to_act: assert property (isWr && caF[0] |=> (!(isAct && bnk == wrBank_q)) [*8])
      else $error("activate too soon after write with auto precharge");
   a_rd_to_wr: assert property (isRd |=> (!isWr) [*6])
      else $error("write too soon after read");
   a_wr_to_rd: assert property (isWr |=> (!isRd) [*7])
      else $error("read too soon after write");
   a_ref_gap: assert property (isRef |=> (!(isRef || isAct)) [*5])
      else $error("command inside refresh time");
   a_no_burst_stop: assert property (!(!csB && caR[3:0] == 4'b0011))
      else $error("burst terminate seen on the link");
endmodule : lp2_link_chk
`default_nettype wire

// [test/lpddr2_precharge_refresh_timing_tb.sv]
// self-checking bench for the lpddr2 controller and device pair
`timescale 1ns/100ps
`default_nettype none
`include "lp2_consts.svh"
module lpddr2_precharge_refresh_timing_tb;
   import lp2_pkg::*;
   localparam int LIMIT = 6000;
   localparam int RDAP  = (`LP2_BLH > `LP2_BLH - 2 + `LP2_RTP_CK) ?
                          `LP2_BLH : `LP2_BLH - 2 + `LP2_RTP_CK;
   localparam int WRAP  = `LP2_WL + `LP2_BLH + 1 + `LP2_WR_CK;
   logic          mclk;
   logic          rst_b;
   logic          reqValid;
   lp2_cmd_e      reqCmd;
   logic [2:0]    reqBank;
   logic          reqAp;
   logic [63:0]   usrWrData;
   logic          reqAck;
   logic          usrWrTake;
   logic [7:0]    ctlBankOpen;
   logic          ctlRefBusy;
   logic [7:0]    devBankOpen;
   logic [7:0]    devBankPrech;
   logic [7:0]    devApStart;
   logic          devRefBusy;
   logic [2:0]    devBankCnt;
   logic          arrayWr;
   logic [2:0]    arrayBank;
   logic [127:0]  arrayData;
   int            err_count = 0;
   int            total_checks = 0;
   int            cyc = 0;
   int            refLen = 0;
   int            ctlLen = 0;
   integer        seed = 32'h09C0;
   logic [7:0]    openExp = 8'h00;
   logic [7:0]    preMask = 8'h00;
   logic [63:0]   prevData = 64'h0;
   logic          hit;
   logic [21:0]   eCmd;
   logic [130:0]  eArr;
   logic [34:0]   eAp;
   lp2_cmd_e      rc;
   logic [31:0]   rr;
   logic [21:0]   expCmd[$];
   logic [130:0]  expArr[$];
   logic [34:0]   expAp[$];
   logic [63:0]   words[$];
   logic [2:0]    wrBanks[$];

   lp2_link_if link (.mclk(mclk));
   lp2_controller u_lp2_controller (.mclk(mclk), .rst_b(rst_b), .link(link),
      .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank), .reqAp(reqAp),
      .usrWrData(usrWrData), .reqAck(reqAck), .usrWrTake(usrWrTake),
      .ctlBankOpen(ctlBankOpen), .ctlRefBusy(ctlRefBusy));
   lp2_device u_lp2_device (.link(link), .rst_b(rst_b), .devBankOpen(devBankOpen),
      .devBankPrech(devBankPrech), .devApStart(devApStart), .devRefBusy(devRefBusy),
      .devBankCnt(devBankCnt), .arrayWr(arrayWr), .arrayBank(arrayBank), .arrayData(arrayData));
   lp2_link_chk u_lp2_link_chk (.mclk(mclk), .rst_b(rst_b), .csB(link.csB), .caR(link.caR),
      .caF(link.caF), .wdq(link.wdq), .wdqValid(link.wdqValid));

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // {mask, value} over {ap, rising command bits}
   function automatic logic [21:0] enc(lp2_cmd_e c, logic [2:0] b, logic ap);
      case (c)
         CMD_ACT:  return {11'h383, 1'b0, b, 7'h02};
         CMD_RD:   return {11'h787, ap, b, 7'h05};
         CMD_WR:   return {11'h787, ap, b, 7'h01};
         CMD_PRE:  return {11'h39F, 1'b0, b, 7'h0B};
         CMD_PREA: return {11'h01F, 4'h0, 7'h1B};
         default:  return {11'h00F, 4'h0, 7'h0C};
      endcase
   endfunction : enc

   task automatic req(input lp2_cmd_e c, input logic [2:0] b, input logic ap);
      int n;
      n = 0;
      expCmd.push_back(enc(c, b, ap));
      @(posedge mclk);
      reqValid <= 1'b1;
      reqCmd <= c;
      reqBank <= b;
      reqAp <= ap;
      do begin
         @(posedge mclk);
         n++;
      end while (reqAck !== 1'b1 && n < 300);
      reqValid <= 1'b0;
      chk(reqAck === 1'b1, "request never taken");
      if (c == CMD_WR) begin
         repeat (`LP2_BL / 4) wrBanks.push_back(b);
      end
      // precharge period of one clock, seen the edge after the device takes it
      if (c == CMD_PRE || c == CMD_PREA) begin
         preMask <= (c == CMD_PREA) ? 8'hFF : 8'(8'h01 << b);
      end
      if ((c == CMD_RD || c == CMD_WR) && ap) begin
         // start edge counts from the device's sampling edge; its flop shows it one edge later
         expAp.push_back({32'(cyc + 1 + ((c == CMD_RD) ? RDAP : WRAP)), b});
         openExp[b] = 1'b0;
      end
      if (c == CMD_ACT) openExp[b] = 1'b1;
      if (c == CMD_PRE) openExp[b] = 1'b0;
      if (c == CMD_PREA || c == CMD_REFA) openExp = 8'h00;
   endtask : req

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         report_and_stop;
      end
   end

   // write words taken at the edge before each take pulse
   always @(posedge mclk) begin
      usrWrData <= {$random(seed), $random(seed)};
      if (usrWrTake === 1'b1) words.push_back(prevData);
      prevData = usrWrData;
      if (words.size() == 2 && wrBanks.size() > 0) begin
         expArr.push_back({wrBanks.pop_front(), words[1], words[0]});
         words.delete();
      end
   end

   always @(posedge mclk) begin
      if (rst_b === 1'b1) begin
         if (reqAck === 1'b1) begin
            hit = expCmd.size() > 0;
            if (hit) eCmd = expCmd.pop_front();
            chk(hit && link.csB === 1'b0 &&
                (({link.caF[0], link.caR} ^ eCmd[10:0]) & eCmd[21:11]) === 11'h000,
                "command encoding");
         end
         if (arrayWr === 1'b1) begin
            hit = expArr.size() > 0;
            if (hit) eArr = expArr.pop_front();
            chk(hit && {arrayBank, arrayData} === eArr, "array write group");
         end
         if (devApStart !== 8'h00) begin
            hit = expAp.size() > 0;
            if (hit) eAp = expAp.pop_front();
            chk(hit && eAp[34:3] === 32'(cyc) && devApStart === (8'h01 << eAp[2:0]),
                "auto precharge start");
         end
         chk(devBankPrech === (preMask | devApStart), "precharge period");
         if (preMask != 8'h00) preMask <= 8'h00;
         if (devRefBusy === 1'b1) refLen++;
         else if (refLen != 0) begin
            chk(refLen == `LP2_RFC_CK, "refresh length");
            chk(devBankOpen === 8'h00 && devBankCnt === 3'h0, "state after refresh");
            refLen = 0;
         end
         if (ctlRefBusy === 1'b1) ctlLen++;
         else if (ctlLen != 0) begin
            chk(ctlLen == `LP2_RFC_CK, "controller refresh length");
            ctlLen = 0;
         end
      end
   end

   initial begin
      rst_b = 1'b0;
      reqValid = 1'b0;
      reqCmd = CMD_NOP;
      reqBank = 3'h0;
      reqAp = 1'b0;
      usrWrData = 64'h0;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      req(CMD_ACT, 3'h0, 1'b0);
      req(CMD_ACT, 3'h1, 1'b0);
      req(CMD_WR, 3'h0, 1'b0);
      req(CMD_WR, 3'h1, 1'b1);
      req(CMD_RD, 3'h0, 1'b1);
      req(CMD_PRE, 3'h0, 1'b0);
      req(CMD_PREA, 3'h0, 1'b0);
      req(CMD_REFA, 3'h0, 1'b0);
      req(CMD_REFA, 3'h0, 1'b0);
      req(CMD_ACT, 3'h2, 1'b0);
      for (int i = 0; i < 80; i++) begin
         rr = $random(seed);
         rc = lp2_cmd_e'(3'h1 + 3'(rr[7:0] % 6));
         if ((rc == CMD_RD || rc == CMD_WR) && !openExp[rr[10:8]]) rc = CMD_ACT;
         else if (rc == CMD_ACT && openExp[rr[10:8]]) rc = CMD_PRE;
         if (rc == CMD_REFA && openExp != 8'h00) rc = CMD_PREA;
         req(rc, rr[10:8], rr[11]);
      end
      repeat (40) @(posedge mclk);
      chk(devBankOpen === openExp && ctlBankOpen === openExp, "open banks");
      chk(expCmd.size() + expArr.size() + expAp.size() == 0, "results missing");
      report_and_stop;
   end
endmodule : lpddr2_precharge_refresh_timing_tb
`default_nettype wire
